/* incr_or_branch_exec.v */
// execution slice: skip-on-zero counts, increment, inclusive or, branch
// assumes fetch and register file run on clk_sys, file reads are combinational
`timescale 1ns/1ns
`include "exec_regs.vh"
module incr_or_branch_exec (
    input wire clk_sys,
    input wire rstn,
    input wire instr_valid,
    input wire [13:0] instr_word,
    input wire [7:0] file_rd_data,
    input wire [7:0] pc_high_latch,
    output wire instr_take,
    output wire cycle_en,
    output wire [6:0] file_rd_addr,
    output wire [7:0] working_register,
    output wire zero_flag,
    output wire zero_wr,
    output wire file_wr_en,
    output wire [6:0] file_wr_addr,
    output wire [7:0] file_wr_data,
    output wire pc_load,
    output wire [12:0] pc_target,
    output wire nop_slot,
    output wire exec_hit
);
    localparam st_exec = 1'b0;
    localparam st_nop = 1'b1;

    function op6_is;
        input [13:0] word;
        input [5:0] pat;
        begin
            op6_is = (word[`OPC6_MSB:`OPC6_LSB] == pat);
        end
    endfunction

    // operation pick for the shared increment / decrement / or unit
    function [1:0] alu_pick;
        input dec;
        input or_f;
        input or_l;
        begin
            if (dec) begin
                alu_pick = `ALU_DEC;
            end else if (or_f) begin
                alu_pick = `ALU_OR_F;
            end else if (or_l) begin
                alu_pick = `ALU_OR_LIT;
            end else begin
                alu_pick = `ALU_INC;
            end
        end
    endfunction

    reg state_ff;
    reg nxt_state;
    reg [7:0] w_ff;
    reg [7:0] nxt_w;
    reg z_ff;
    reg nxt_z;
    reg z_wr_ff;
    reg nxt_z_wr;
    reg f_wr_ff;
    reg nxt_f_wr;
    reg [6:0] f_addr_ff;
    reg [6:0] nxt_f_addr;
    reg [7:0] f_data_ff;
    reg [7:0] nxt_f_data;
    reg pc_load_ff;
    reg nxt_pc_load;
    reg [12:0] pc_ff;
    reg [12:0] nxt_pc;
    reg nop_ff;
    reg nxt_nop;
    reg hit_ff;
    reg nxt_hit;

    wire tcy_en;
    wire is_dec_skip;
    wire is_inc_skip;
    wire is_inc;
    wire is_or_wf;
    wire is_or_lit;
    wire is_branch;
    wire is_file_op;
    wire dest_file;
    wire [1:0] alu_sel;
    wire [7:0] alu_result;
    wire alu_zero;
    wire slot_exec;
    wire take_file;
    wire take_lit;
    wire take_branch;
    wire skip_zero;
    wire flag_op;

    tcy_divider u_div (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .tcy_en(tcy_en)
    );

    // decode
    assign is_dec_skip = op6_is(instr_word, `OPC_DEC_SKIP);
    assign is_inc_skip = op6_is(instr_word, `OPC_INC_SKIP);
    assign is_inc = op6_is(instr_word, `OPC_INC);
    assign is_or_wf = op6_is(instr_word, `OPC_OR_WF);
    assign is_or_lit = op6_is(instr_word, `OPC_OR_LIT);
    assign is_branch = (instr_word[`OPC3_MSB:`OPC3_LSB] == `OPC_BRANCH);
    assign is_file_op = is_dec_skip | is_inc_skip | is_inc | is_or_wf;
    assign dest_file = instr_word[`DEST_BIT];

    assign alu_sel = alu_pick(is_dec_skip, is_or_wf, is_or_lit);

    exec_alu u_alu (
        .op_sel(alu_sel),
        .file_val(file_rd_data),
        .work_val(w_ff),
        .lit_val(instr_word[`LIT8_MSB:0]),
        .result(alu_result),
        .result_zero(alu_zero)
    );

    // nothing is written during a no-operation slot
    assign slot_exec = tcy_en && (state_ff == st_exec);
    assign take_file = slot_exec && instr_valid && is_file_op;
    assign take_lit = slot_exec && instr_valid && is_or_lit;
    assign take_branch = slot_exec && instr_valid && is_branch;
    assign skip_zero = (is_dec_skip || is_inc_skip) && alu_zero;
    assign flag_op = is_inc || is_or_wf;

    // sequencer: a skip or a jump spends the next slot as a no-operation
    always @* begin
        nxt_state = state_ff;
        if (tcy_en) begin
            case (state_ff)
                st_exec: begin
                    if (take_file && skip_zero) begin
                        nxt_state = st_nop;
                    end else if (take_branch) begin
                        // prefetched word is stale after the jump
                        nxt_state = st_nop;
                    end
                end
                st_nop: begin
                    nxt_state = st_exec;
                end
                default: begin
                    nxt_state = st_exec;
                end
            endcase
        end
    end

    always @* begin
        nxt_w = w_ff;
        // destination select: 0 working, 1 file
        if (take_file && !dest_file) begin
            nxt_w = alu_result;
        end else if (take_lit) begin
            nxt_w = alu_result;
        end
    end

    // skip forms leave the flags alone
    always @* begin
        nxt_z = z_ff;
        nxt_z_wr = 1'b0;
        if ((take_file && flag_op) || take_lit) begin
            nxt_z = alu_zero;
            nxt_z_wr = 1'b1;
        end
    end

    always @* begin
        nxt_f_wr = 1'b0;
        nxt_f_addr = f_addr_ff;
        nxt_f_data = f_data_ff;
        if (take_file && dest_file) begin
            nxt_f_wr = 1'b1;
            nxt_f_addr = instr_word[`FADDR_MSB:0];
            nxt_f_data = alu_result;
        end
    end

    always @* begin
        nxt_pc_load = 1'b0;
        nxt_pc = pc_ff;
        if (take_branch) begin
            nxt_pc_load = 1'b1;
            // latch is only read here, never written
            nxt_pc = {pc_high_latch[`PCH_MSB:`PCH_LSB],
                      instr_word[`LIT11_MSB:0]};
        end
    end

    always @* begin
        nxt_hit = take_file || take_lit || take_branch;
        // word in this slot is consumed and discarded
        nxt_nop = tcy_en && (state_ff == st_nop);
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_ff <= st_exec;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            w_ff <= `W_RST;
        end else begin
            w_ff <= nxt_w;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            z_ff <= `Z_RST;
        end else begin
            z_ff <= nxt_z;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            z_wr_ff <= `PULSE_RST;
        end else begin
            z_wr_ff <= nxt_z_wr;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            f_wr_ff <= `PULSE_RST;
        end else begin
            f_wr_ff <= nxt_f_wr;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            f_addr_ff <= `FADDR_RST;
        end else begin
            f_addr_ff <= nxt_f_addr;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            f_data_ff <= `FDATA_RST;
        end else begin
            f_data_ff <= nxt_f_data;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pc_load_ff <= `PULSE_RST;
        end else begin
            pc_load_ff <= nxt_pc_load;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pc_ff <= `PC_RST;
        end else begin
            pc_ff <= nxt_pc;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            nop_ff <= `PULSE_RST;
        end else begin
            nop_ff <= nxt_nop;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            hit_ff <= `PULSE_RST;
        end else begin
            hit_ff <= nxt_hit;
        end
    end

    // one word taken per instruction_cycle, whatever it decodes to
    assign instr_take = tcy_en & instr_valid;
    assign cycle_en = tcy_en;
    assign file_rd_addr = instr_word[`FADDR_MSB:0];
    assign working_register = w_ff;
    assign zero_flag = z_ff;
    assign zero_wr = z_wr_ff;
    assign file_wr_en = f_wr_ff;
    assign file_wr_addr = f_addr_ff;
    assign file_wr_data = f_data_ff;
    assign pc_load = pc_load_ff;
    assign pc_target = pc_ff;
    assign nop_slot = nop_ff;
    assign exec_hit = hit_ff;
endmodule // incr_or_branch_exec

/* exec_regs.vh */
// constants for the increment / or / branch execution slice
// assumes a 14-bit instruction word and an 8-bit file register bus
//
// What this block does
// - decrement_skip_if_zero: file minus one to working or file; flags untouched.
// - decrement result zero: next instruction becomes a no-operation, two cycles.
// - increment_skip_if_zero: file plus one to working or file; flags untouched.
// - increment wraps to zero: next instruction becomes a no-operation, two cycles.
// - unconditional_branch: 11-bit literal goes to program counter bits 10:0.
// - branch: counter bits 12:11 from high latch bits 4:3; latch unchanged.
// - every unconditional_branch takes two instruction cycles.
// - or_literal_into_working: working OR 8-bit literal into working, zero_flag updated.
// - increment_register: file plus one to chosen destination, zero_flag updated.
// - or_working_with_register: working OR file to chosen destination, zero_flag updated.
`ifndef EXEC_REGS_VH
`define EXEC_REGS_VH

// clocks of clk_sys per instruction_cycle
`define TCY_CLKS 4
`define TCY_CNT_W 2
`define TCY_LAST 2'h3

// instruction word fields
`define IW_W 14
`define OPC6_MSB 13
`define OPC6_LSB 8
`define OPC3_MSB 13
`define OPC3_LSB 11
`define DEST_BIT 7
`define FADDR_MSB 6
`define LIT8_MSB 7
`define LIT11_MSB 10
`define PCH_MSB 4
`define PCH_LSB 3

// opcode patterns
`define OPC_DEC_SKIP 6'h0b
`define OPC_INC_SKIP 6'h0f
`define OPC_INC 6'h0a
`define OPC_OR_WF 6'h04
`define OPC_OR_LIT 6'h38
`define OPC_BRANCH 3'h5

// alu operation selects
`define ALU_INC 2'h0
`define ALU_DEC 2'h1
`define ALU_OR_F 2'h2
`define ALU_OR_LIT 2'h3

// reset values
`define W_RST 8'h00
`define Z_RST 1'b0
`define PC_RST 13'h0000
`define FADDR_RST 7'h00
`define FDATA_RST 8'h00
`define PULSE_RST 1'b0

`endif

/* tcy_divider.v */
// instruction_cycle strobe generator
// assumes clk_sys is the only clock
`timescale 1ns/1ns
`include "exec_regs.vh"
module tcy_divider (
    input wire clk_sys,
    input wire rstn,
    output wire tcy_en
);
    localparam [`TCY_CNT_W-1:0] last_cnt = `TCY_LAST;
    reg [`TCY_CNT_W-1:0] cnt_ff;
    wire [`TCY_CNT_W-1:0] nxt_cnt;

    assign nxt_cnt = (cnt_ff == last_cnt) ? {`TCY_CNT_W{1'b0}} : cnt_ff + 1'b1;
    // strobe on the last count so the first cycle completes after reset
    assign tcy_en = (cnt_ff == last_cnt);

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= {`TCY_CNT_W{1'b0}};
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule // tcy_divider

/* exec_alu.v */
// 8-bit arithmetic for increment, decrement and inclusive or
// assumes operands are stable for the whole instruction_cycle
`timescale 1ns/1ns
`include "exec_regs.vh"
module exec_alu (
    input wire [1:0] op_sel,
    input wire [7:0] file_val,
    input wire [7:0] work_val,
    input wire [7:0] lit_val,
    output reg [7:0] result,
    output wire result_zero
);
    always @* begin
        case (op_sel)
            `ALU_INC: result = file_val + 8'h01;
            `ALU_DEC: result = file_val - 8'h01;
            `ALU_OR_F: result = work_val | file_val;
            `ALU_OR_LIT: result = work_val | lit_val;
            default: result = 8'h00;
        endcase
    end

    // eight bits only: a carry out of the increment is not part of the test
    assign result_zero = (result == 8'h00);
endmodule // exec_alu

/* incr_or_branch_exec_asserts.sv */
// checker for the execution slice, port level only
// assumes it is bound onto incr_or_branch_exec by the bench
`timescale 1ns/1ns
module incr_or_branch_exec_asserts (
    input logic clk_sys,
    input logic rstn,
    input logic instr_valid,
    input logic [13:0] instr_word,
    input logic [7:0] file_rd_data,
    input logic [7:0] pc_high_latch,
    input logic instr_take,
    input logic cycle_en,
    input logic [6:0] file_rd_addr,
    input logic [7:0] working_register,
    input logic zero_flag,
    input logic zero_wr,
    input logic file_wr_en,
    input logic [6:0] file_wr_addr,
    input logic [7:0] file_wr_data,
    input logic pc_load,
    input logic [12:0] pc_target,
    input logic nop_slot,
    input logic exec_hit
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire [7:0] res = file_wr_en ? file_wr_data : working_register;
    sequence dec_zero;
        instr_take && instr_word[13:8] == 6'h0b && file_rd_data == 8'h01 ##1 exec_hit;
    endsequence
    sequence inc_zero;
        instr_take && instr_word[13:8] == 6'h0f && file_rd_data == 8'hff ##1 exec_hit;
    endsequence
    sequence branch_done;
        pc_load ##3 instr_take;
    endsequence
    strobe_period_a: assert property (cycle_en |=> !cycle_en [*3] ##1 cycle_en)
        else $error("cycle strobe spacing wrong");
    dec_skip_a: assert property (dec_zero ##3 instr_take |=> nop_slot && !exec_hit)
        else $error("decrement to zero did not skip");
    inc_skip_a: assert property (inc_zero ##3 instr_take |=> nop_slot && !exec_hit)
        else $error("increment wrap did not skip");
    branch_skip_a: assert property (branch_done |=> nop_slot && !pc_load)
        else $error("branch second cycle not idle");
    branch_target_a: assert property (pc_load |->
        pc_target == {$past(pc_high_latch[4:3]), $past(instr_word[10:0])})
        else $error("branch target wrong");
    skip_flags_a: assert property (exec_hit &&
        ($past(instr_word[13:8]) & 6'h3b) == 6'h0b |->
        !zero_wr && $stable(zero_flag) && file_wr_en == $past(instr_word[7]))
        else $error("skip count touched flag or wrong destination");
    incr_value_a: assert property (exec_hit && $past(instr_word[13:8]) == 6'h0a |->
        zero_wr && res == 8'($past(file_rd_data) + 8'h01))
        else $error("increment result wrong");
    or_lit_a: assert property (exec_hit && $past(instr_word[13:8]) == 6'h38 |->
        !file_wr_en && working_register == ($past(working_register) | $past(instr_word[7:0])))
        else $error("literal or result wrong");
    or_file_a: assert property (exec_hit && $past(instr_word[13:8]) == 6'h04 |->
        file_wr_en == $past(instr_word[7]) &&
        res == ($past(working_register) | $past(file_rd_data)))
        else $error("register or result wrong");
    zero_value_a: assert property (zero_wr |-> zero_flag == (res == 8'h00))
        else $error("zero flag disagrees with result");
endmodule // incr_or_branch_exec_asserts

/* incr_or_branch_exec_bench.sv */
// bench: directed then random words against an integer model
// assumes the bench plays fetch and register file, one word per strobe
`timescale 1ns/1ns
module incr_or_branch_exec_bench;
    logic clk_sys, rstn, instr_valid, instr_take, cycle_en, zero_flag, zero_wr;
    logic file_wr_en, pc_load, nop_slot, exec_hit, zm = 1'b0, skip = 1'b0;
    logic [13:0] instr_word, w;
    logic [7:0] file_rd_data, pc_high_latch, working_register, file_wr_data, wm = 8'h00;
    logic [6:0] file_rd_addr, file_wr_addr;
    logic [12:0] pc_target, pct, pcm = 13'h0000;
    logic [7:0] rf [0:127];
    logic [7:0] mf [0:127];
    logic [31:0] seed = 32'hc29ebe51;
    logic [5:0] ops [8] = '{6'h0b, 6'h0f, 6'h0a, 6'h04, 6'h38, 6'h28, 6'h3f, 6'h0b};
    logic [13:0] dir [11] = '{14'h0b80, 14'h0a00, 14'h0f01, 14'h3800, 14'h3800, 14'h0a81,
        14'h0402, 14'h2923, 14'h0a02, 14'h3fff, 14'h0b82};
    int n_errors = 0, checks_done = 0, cyc = 0, n_nop = 0, e_nop = 0;
    incr_or_branch_exec u_incr_or_branch_exec (.*);
    assign file_rd_data = rf[file_rd_addr];
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // far side register file; timeout well above ~1300 cycles of traffic
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (!rstn) begin
            pct <= 13'h0000;
            for (int i = 0; i < 128; i++) rf[i] <= 8'(8'h01 - 2 * i);
        end
        if (file_wr_en) rf[file_wr_addr] <= file_wr_data;
        if (pc_load) pct <= pc_target;
        if (nop_slot) n_nop <= n_nop + 1;
        if (cyc == 5000) begin
            n_errors++;
            summarize();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic run(input logic [13:0] iw, input logic [7:0] lat);
        logic [7:0] r;
        logic hit, sk;
        @(posedge clk_sys);
        instr_word <= iw;
        pc_high_latch <= lat;
        instr_valid <= 1'b1;
        do @(negedge clk_sys); while (instr_take !== 1'b1);
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        hit = iw[13:8] inside {6'h0b, 6'h0f, 6'h0a, 6'h04, 6'h38};
        sk = iw[13:8] inside {6'h0b, 6'h0f};
        case (iw[13:8])
            6'h0b: r = mf[iw[6:0]] - 8'h01;
            6'h0f, 6'h0a: r = mf[iw[6:0]] + 8'h01;
            6'h04: r = wm | mf[iw[6:0]];
            default: r = wm | iw[7:0];
        endcase
        if (skip) begin
            skip = 1'b0;
            e_nop++;
        end else if (iw[13:11] == 3'h5) begin
            pcm = {lat[4:3], iw[10:0]};
            skip = 1'b1;
        end else if (hit) begin
            if (iw[13:8] == 6'h38 || !iw[7]) wm = r;
            else mf[iw[6:0]] = r;
            if (sk) skip = (r == 8'h00);
            else zm = (r == 8'h00);
        end
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(working_register, wm);
        chk(zero_flag, zm);
        chk(rf[iw[6:0]], mf[iw[6:0]]);
        chk(pct, pcm);
        chk(16'(n_nop), 16'(e_nop));
    endtask
    initial begin
        rstn = 1'b0;
        instr_valid = 1'b0;
        instr_word = 14'h0000;
        pc_high_latch = 8'h00;
        // low registers start next to the wrap points so skips happen often
        for (int i = 0; i < 128; i++) begin
            mf[i] = 8'(8'h01 - 2 * i);
        end
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        foreach (dir[i]) run(dir[i], 8'h18);
        $display("directed words done");
        repeat (300) begin
            seed = xs(seed);
            w = {ops[seed[2:0]], seed[15:8]};
            if (!w[13]) w[6:2] = 5'h00;
            if (w[13:11] == 3'h5) w[10:8] = seed[18:16];
            run(w, seed[31:24]);
        end
        $display("random words done");
        summarize();
    end
endmodule // incr_or_branch_exec_bench
bind incr_or_branch_exec incr_or_branch_exec_asserts u_incr_or_branch_exec_asserts (.*);
